// File: hdl/cpusb_defines.vh
`ifndef CPUSB_DEFINES_VH
`define CPUSB_DEFINES_VH

// Bus register byte offsets
`define CPUSB_OFF_PSW       8'h00
`define CPUSB_OFF_ACC       8'h04
`define CPUSB_OFF_WREG_SEL  8'h08
`define CPUSB_OFF_WREG_DATA 8'h0C
`define CPUSB_OFF_IRAM_ADDR 8'h10
`define CPUSB_OFF_IRAM_DATA 8'h14
`define CPUSB_OFF_SFR_PROBE 8'h18
`define CPUSB_OFF_XDATA     8'h1C
`define CPUSB_OFF_PC        8'h20
`define CPUSB_OFF_STATUS    8'h24

// Status word fields
`define CPUSB_PSW_CARRY     7
`define CPUSB_PSW_HALF      6
`define CPUSB_PSW_UF0       5
`define CPUSB_PSW_BANK_HI   4
`define CPUSB_PSW_BANK_LO   3
`define CPUSB_PSW_OVF       2
`define CPUSB_PSW_UF1       1
`define CPUSB_PSW_PARITY    0
`define CPUSB_PSW_RESET     8'h00
`define CPUSB_ACC_RESET     8'h00
`define CPUSB_PSW_SFR_ADDR  8'hD0

// Address spaces
`define CPUSB_IRAM_AW       8
`define CPUSB_IRAM_BYTES    256
`define CPUSB_SFR_BASE      8'h80
`define CPUSB_SFR_BYTES     128
`define CPUSB_BITADDR_MASK  8'h07
`define CPUSB_PROG_AW       16
`define CPUSB_XDATA_AW      16
`define CPUSB_ON_CHIP_EXTENDED_DATA_RAM_BYTES    2048
`define CPUSB_ON_CHIP_EXTENDED_DATA_RAM_AW       11
`define CPUSB_WREG_TOP      3'b000
`define CPUSB_WREG_LIMIT    8'h20

// Reset pin hold in oscillator periods, and oscillator periods per machine cycle
`define CPUSB_RST_OSC_PERIODS 24
`define CPUSB_OSC_PER_MCYCLE  12

// AXI responses
`define CPUSB_RESP_OKAY     2'b00
`define CPUSB_RESP_SLVERR   2'b10

`endif

// File: hdl/cpusb_ram.v
`timescale 1ns/1ps
module cpusb_ram #(
    parameter AW = 8,
    parameter DW = 8
) (
    input  wire          aclk,    // Clock
    input  wire          we,      // Write enable
    input  wire [AW-1:0] waddr,   // Write address
    input  wire [DW-1:0] wdata,   // Write data
    input  wire [AW-1:0] raddr,   // Read address
    output reg  [DW-1:0] rdata_r  // Registered read data
);

    reg [DW-1:0] mem [0:(1<<AW)-1];

    always @(posedge aclk)
    begin
        if (we)
        begin
            mem[waddr] <= wdata;
        end
        rdata_r <= mem[raddr];
    end

endmodule // cpusb_ram

// File: hdl/cpusb_core.v
// Decided for this implementation: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "cpusb_defines.vh"
module cpusb_core #(
    parameter [15:0] ON_CHIP_EXTENDED_DATA_RAM_BASE = 16'hF800
) (
    input  wire        aclk,          // 20 MHz clock
    input  wire        aresetn,       // Sync reset, active low
    input  wire        reset_pin_n,   // External reset pin, active low
    input  wire [7:0]  s_axi_awaddr,  // Write address
    input  wire        s_axi_awvalid, // Write address valid
    output reg         s_axi_awready, // Write address ready
    input  wire [31:0] s_axi_wdata,   // Write data
    input  wire [3:0]  s_axi_wstrb,   // Write strobes
    input  wire        s_axi_wvalid,  // Write data valid
    output reg         s_axi_wready,  // Write data ready
    output reg  [1:0]  s_axi_bresp,   // Write response
    output reg         s_axi_bvalid,  // Write response valid
    input  wire        s_axi_bready,  // Write response ready
    input  wire [7:0]  s_axi_araddr,  // Read address
    input  wire        s_axi_arvalid, // Read address valid
    output reg         s_axi_arready, // Read address ready
    output reg  [31:0] s_axi_rdata,   // Read data
    output reg  [1:0]  s_axi_rresp,   // Read response
    output reg         s_axi_rvalid,  // Read data valid
    input  wire        s_axi_rready,  // Read data ready
    output reg  [1:0]  bank_sel_r,    // Active register bank
    output reg         parity_flag_r, // Accumulator parity
    output reg         core_reset_r   // Core held in reset
);

    // Reset pin synchroniser and core reset
    reg        rst_meta_r;
    reg        rst_sync_r;
    wire       core_rst;

    // Write channel state
    reg        aw_full_r;
    reg        w_full_r;
    reg [7:0]  aw_addr_r;
    reg [31:0] w_data_r;
    reg [3:0]  w_strb_r;
    reg        aw_full_nxt;
    reg        w_full_nxt;
    wire       do_write;
    reg        wr_ok;

    // Read channel state
    reg        rd_wait_r;
    reg        rd_fin_r;
    reg [7:0]  ar_addr_r;
    reg        ar_busy_nxt;
    reg [31:0] rd_val;
    reg        rd_ok;

    // Core registers
    reg [7:0]  psw_r;
    reg [7:0]  acc_r;
    reg        instr_done_r;
    reg [2:0]  wreg_sel_r;
    reg [7:0]  iram_addr_r;
    reg [7:0]  sfr_probe_r;
    reg [15:0] xdata_addr_r;
    reg [15:0] pc_r;

    // Internal data memory ports
    reg        ram_we;
    reg [7:0]  ram_waddr;
    reg [7:0]  ram_raddr;
    wire [7:0] ram_rdata;
    wire [7:0] wreg_addr;

    // Address classification
    wire       sfr_space;
    wire       sfr_bitaddr;
    wire       sfr_is_psw;
    wire       wreg_region;
    wire [15:0] on_chip_extended_data_ram_off;
    wire       on_chip_extended_data_ram_hit;

    // Two flops before anyone looks at the pin
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rst_meta_r <= 1'b0;
            rst_sync_r <= 1'b0;
        end
        else
        begin
            rst_meta_r <= reset_pin_n;
            rst_sync_r <= rst_meta_r;
        end
    end

    // Pin pulses shorter than one clock period may be missed
    assign core_rst = !aresetn || !rst_sync_r;

    always @(posedge aclk)
    begin
        core_reset_r <= core_rst;
    end

    // Bank n covers 8n..8n+7
    assign wreg_addr = {`CPUSB_WREG_TOP,
                        psw_r[`CPUSB_PSW_BANK_HI:`CPUSB_PSW_BANK_LO],
                        wreg_sel_r};

    // Upper half of the byte address space is the register area
    assign sfr_space   = sfr_probe_r[7];
    assign sfr_bitaddr = sfr_space &&
        ((sfr_probe_r & `CPUSB_BITADDR_MASK) == 8'h00);
    assign sfr_is_psw  = sfr_probe_r == `CPUSB_PSW_SFR_ADDR;
    assign wreg_region = iram_addr_r < `CPUSB_WREG_LIMIT;

    // 2K on-chip block inside the 64K data space
    assign on_chip_extended_data_ram_off = xdata_addr_r - ON_CHIP_EXTENDED_DATA_RAM_BASE;
    assign on_chip_extended_data_ram_hit = on_chip_extended_data_ram_off < `CPUSB_ON_CHIP_EXTENDED_DATA_RAM_BYTES;

    // Write channel: address and data taken in either order
    assign do_write = aw_full_r && w_full_r && !s_axi_bvalid;

    always @*
    begin
        aw_full_nxt = aw_full_r;
        w_full_nxt  = w_full_r;
        if (s_axi_awvalid && s_axi_awready)
        begin
            aw_full_nxt = 1'b1;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            w_full_nxt = 1'b1;
        end
        if (s_axi_bvalid && s_axi_bready)
        begin
            aw_full_nxt = 1'b0;
            w_full_nxt  = 1'b0;
        end
    end

    always @*
    begin
        case (aw_addr_r)
            `CPUSB_OFF_PSW,
            `CPUSB_OFF_ACC,
            `CPUSB_OFF_WREG_SEL,
            `CPUSB_OFF_WREG_DATA,
            `CPUSB_OFF_IRAM_ADDR,
            `CPUSB_OFF_IRAM_DATA,
            `CPUSB_OFF_SFR_PROBE,
            `CPUSB_OFF_XDATA,
            `CPUSB_OFF_PC:
                wr_ok = 1'b1;
            default:
                wr_ok = 1'b0;
        endcase
    end

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_full_r     <= 1'b0;
            w_full_r      <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `CPUSB_RESP_OKAY;
            aw_addr_r     <= 8'h00;
            w_data_r      <= 32'h0000_0000;
            w_strb_r      <= 4'h0;
        end
        else
        begin
            aw_full_r     <= aw_full_nxt;
            w_full_r      <= w_full_nxt;
            s_axi_awready <= !aw_full_nxt;
            s_axi_wready  <= !w_full_nxt;
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_addr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
            if (do_write)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_ok ? `CPUSB_RESP_OKAY
                                      : `CPUSB_RESP_SLVERR;
            end
            else if (s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Memory ports: writes from the bus, reads staged for the read channel
    always @*
    begin
        ram_we    = 1'b0;
        ram_waddr = iram_addr_r;
        if (do_write && w_strb_r[0])
        begin
            if (aw_addr_r == `CPUSB_OFF_WREG_DATA)
            begin
                ram_we    = 1'b1;
                ram_waddr = wreg_addr;
            end
            else if (aw_addr_r == `CPUSB_OFF_IRAM_DATA)
            begin
                ram_we = 1'b1;
            end
        end
        if (ar_addr_r == `CPUSB_OFF_WREG_DATA)
        begin
            ram_raddr = wreg_addr;
        end
        else
        begin
            ram_raddr = iram_addr_r;
        end
    end

    cpusb_ram #(
        .AW (`CPUSB_IRAM_AW),
        .DW (8)
    ) u_iram (
        .aclk    (aclk),
        .we      (ram_we),
        .waddr   (ram_waddr),
        .wdata   (w_data_r[7:0]),
        .raddr   (ram_raddr),
        .rdata_r (ram_rdata)
    );

    // Core state; the accumulator write stands for an instruction
    always @(posedge aclk)
    begin
        if (core_rst)
        begin
            psw_r        <= `CPUSB_PSW_RESET;
            acc_r        <= `CPUSB_ACC_RESET;
            instr_done_r <= 1'b0;
            pc_r         <= 16'h0000;
        end
        else
        begin
            instr_done_r <= 1'b0;
            if (do_write && w_strb_r[0])
            begin
                if (aw_addr_r == `CPUSB_OFF_PSW)
                begin
                    // Parity is owned by hardware
                    psw_r[7:1] <= w_data_r[7:1];
                end
                if (aw_addr_r == `CPUSB_OFF_ACC)
                begin
                    acc_r        <= w_data_r[7:0];
                    instr_done_r <= 1'b1;
                end
            end
            if (do_write && aw_addr_r == `CPUSB_OFF_PC)
            begin
                if (w_strb_r[0])
                begin
                    pc_r[7:0] <= w_data_r[7:0];
                end
                if (w_strb_r[1])
                begin
                    pc_r[15:8] <= w_data_r[15:8];
                end
            end
            if (instr_done_r)
            begin
                psw_r[`CPUSB_PSW_PARITY] <= ^acc_r;
            end
        end
    end

    // Bus-side helper registers, reset with the bus
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            wreg_sel_r   <= 3'b000;
            iram_addr_r  <= 8'h00;
            sfr_probe_r  <= `CPUSB_SFR_BASE;
            xdata_addr_r <= 16'h0000;
        end
        else if (do_write)
        begin
            case (aw_addr_r)
                `CPUSB_OFF_WREG_SEL:
                    if (w_strb_r[0])
                    begin
                        wreg_sel_r <= w_data_r[2:0];
                    end
                `CPUSB_OFF_IRAM_ADDR:
                    if (w_strb_r[0])
                    begin
                        iram_addr_r <= w_data_r[7:0];
                    end
                `CPUSB_OFF_SFR_PROBE:
                    if (w_strb_r[0])
                    begin
                        sfr_probe_r <= w_data_r[7:0];
                    end
                `CPUSB_OFF_XDATA:
                    begin
                        if (w_strb_r[0])
                        begin
                            xdata_addr_r[7:0] <= w_data_r[7:0];
                        end
                        if (w_strb_r[1])
                        begin
                            xdata_addr_r[15:8] <= w_data_r[15:8];
                        end
                    end
                default:
                    wreg_sel_r <= wreg_sel_r;
            endcase
        end
    end

    // Read data mux
    always @*
    begin
        rd_ok  = 1'b1;
        rd_val = 32'h0000_0000;
        case (ar_addr_r)
            `CPUSB_OFF_PSW:
                rd_val[7:0] = psw_r;
            `CPUSB_OFF_ACC:
                rd_val[7:0] = acc_r;
            `CPUSB_OFF_WREG_SEL:
                rd_val[7:0] = wreg_addr;
            `CPUSB_OFF_WREG_DATA,
            `CPUSB_OFF_IRAM_DATA:
                rd_val[7:0] = ram_rdata;
            `CPUSB_OFF_IRAM_ADDR:
                rd_val[8:0] = {wreg_region, iram_addr_r};
            `CPUSB_OFF_SFR_PROBE:
                rd_val[10:0] = {sfr_is_psw, sfr_bitaddr,
                                sfr_space, sfr_probe_r};
            `CPUSB_OFF_XDATA:
                rd_val[16:0] = {on_chip_extended_data_ram_hit, xdata_addr_r};
            `CPUSB_OFF_PC:
                rd_val[15:0] = pc_r;
            `CPUSB_OFF_STATUS:
                rd_val[3:0] = {core_reset_r, parity_flag_r,
                               bank_sel_r};
            default:
                rd_ok = 1'b0;
        endcase
    end

    // Read channel: one wait cycle for the registered memory output
    always @*
    begin
        ar_busy_nxt = rd_wait_r || rd_fin_r || s_axi_rvalid;
        if (s_axi_arvalid && s_axi_arready)
        begin
            ar_busy_nxt = 1'b1;
        end
        if (s_axi_rvalid && s_axi_rready)
        begin
            ar_busy_nxt = 1'b0;
        end
    end

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `CPUSB_RESP_OKAY;
            rd_wait_r     <= 1'b0;
            rd_fin_r      <= 1'b0;
            ar_addr_r     <= 8'h00;
        end
        else
        begin
            s_axi_arready <= !ar_busy_nxt;
            rd_wait_r     <= s_axi_arvalid && s_axi_arready;
            rd_fin_r      <= rd_wait_r;
            if (s_axi_arvalid && s_axi_arready)
            begin
                ar_addr_r <= s_axi_araddr;
            end
            if (rd_fin_r)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_val;
                s_axi_rresp  <= rd_ok ? `CPUSB_RESP_OKAY
                                      : `CPUSB_RESP_SLVERR;
            end
            else if (s_axi_rready)
            begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // Status outputs
    always @(posedge aclk)
    begin
        if (core_rst)
        begin
            bank_sel_r    <= 2'b00;
            parity_flag_r <= 1'b0;
        end
        else
        begin
            bank_sel_r    <= psw_r[`CPUSB_PSW_BANK_HI:`CPUSB_PSW_BANK_LO];
            parity_flag_r <= psw_r[`CPUSB_PSW_PARITY];
        end
    end

endmodule // cpusb_core

// File: dv/cpusb_core_chk.sv
`timescale 1ns/1ps
module cpusb_core_chk (
    input wire        aclk,          // Clock
    input wire        aresetn,       // Bus reset
    input wire        reset_pin_n,   // Reset pin
    input wire        s_axi_awvalid, // AW valid
    input wire        s_axi_awready, // AW ready
    input wire        s_axi_wvalid,  // W valid
    input wire        s_axi_wready,  // W ready
    input wire [1:0]  s_axi_bresp,   // B response
    input wire        s_axi_bvalid,  // B valid
    input wire        s_axi_bready,  // B ready
    input wire        s_axi_arvalid, // AR valid
    input wire        s_axi_arready, // AR ready
    input wire [31:0] s_axi_rdata,   // Read data
    input wire        s_axi_rvalid,  // R valid
    input wire        s_axi_rready,  // R ready
    input wire [1:0]  bank_sel_r,    // Active bank
    input wire        parity_flag_r, // Parity
    input wire        core_reset_r   // Core reset
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    a_pin_reaches: assert property (
        (!reset_pin_n)[*3] |=> core_reset_r)
        else $error("pin reset did not reach core");
    // Two sync flops: a fresh low pin must not act at once
    a_pin_synced: assert property (
        reset_pin_n[*2] ##1 (!reset_pin_n && !core_reset_r) |=> !core_reset_r)
        else $error("pin reset acted without synchronisation");
    a_reset_clears: assert property (
        core_reset_r[*2] |=> bank_sel_r == 2'h0 && !parity_flag_r)
        else $error("status word not cleared by reset");
    a_bank_cause: assert property (
        $changed(bank_sel_r) |->
            s_axi_bvalid || $past(s_axi_bvalid) || core_reset_r)
        else $error("bank changed without a write");
    a_parity_cause: assert property (
        $changed(parity_flag_r) |->
            $past(s_axi_bvalid) || $past(s_axi_bvalid, 2) || core_reset_r)
        else $error("parity changed without an instruction");
    a_resp_holds: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    a_rdata_holds: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    a_read_answer: assert property (
        s_axi_arvalid && s_axi_arready |-> ##[1:4] s_axi_rvalid)
        else $error("read not answered in time");
    a_write_answer: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
            |-> ##[1:3] s_axi_bvalid)
        else $error("write not answered in time");
    a_aw_blocked: assert property (
        s_axi_bvalid |-> !s_axi_awready)
        else $error("new write taken before response");
endmodule // cpusb_core_chk

bind cpusb_core cpusb_core_chk u_chk (
    .aclk(aclk), .aresetn(aresetn), .reset_pin_n(reset_pin_n),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .bank_sel_r(bank_sel_r), .parity_flag_r(parity_flag_r),
    .core_reset_r(core_reset_r)
);

// File: dv/cpu_status_bank_select_reset_test.sv
`timescale 1ns/1ps
`include "cpusb_defines.vh"
module cpu_status_bank_select_reset_test;
    localparam [15:0] XB = 16'hF800;
    reg         aclk = 1'b0;
    reg         aresetn = 1'b0;
    reg         pin_n = 1'b1;
    reg  [7:0]  awa = 8'h00;
    reg         awv = 1'b0;
    reg  [31:0] wda = 32'h0000_0000;
    reg  [3:0]  wst = 4'h0;
    reg         wv = 1'b0;
    reg         bry = 1'b0;
    reg  [7:0]  ara = 8'h00;
    reg         arv = 1'b0;
    reg         rry = 1'b0;
    wire        awr, wrd, bv, arr, rv, par, crst;
    wire [1:0]  bresp, rresp, bank;
    wire [31:0] rdat;
    integer     fail_count = 0;
    integer     checks_done = 0;
    integer     seed = 32'h27a0;
    integer     i;
    reg  [31:0] rd;
    reg  [1:0]  rs;
    reg  [7:0]  a, acc_m, psw_m;
    reg  [15:0] x;

    always #25 aclk = ~aclk;

    cpusb_core #(.ON_CHIP_EXTENDED_DATA_RAM_BASE(XB)) u_cpusb_core (
        .aclk(aclk), .aresetn(aresetn), .reset_pin_n(pin_n),
        .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_wdata(wda), .s_axi_wstrb(wst), .s_axi_wvalid(wv),
        .s_axi_wready(wrd), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
        .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rresp),
        .s_axi_rvalid(rv), .s_axi_rready(rry), .bank_sel_r(bank),
        .parity_flag_r(par), .core_reset_r(crst)
    );

    task chk_data(input [31:0] got, input [31:0] exp);
    begin
        checks_done = checks_done + 1;
        if (got !== exp)
        begin
            fail_count = fail_count + 1;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    end
    endtask

    task chk_resp(input [1:0] got, input [1:0] exp);
    begin
        checks_done = checks_done + 1;
        if (got !== exp)
        begin
            fail_count = fail_count + 1;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    end
    endtask

    task tally_and_finish;
    begin
        if (fail_count == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    end
    endtask

    // Ready is only trusted at edges; each channel drops once taken
    task wr(input [7:0] ad, input [31:0] d, input [3:0] s);
        integer n;
    begin
        @(posedge aclk);
        awa <= ad;
        wda <= d;
        wst <= s;
        awv <= 1'b1;
        wv <= 1'b1;
        bry <= 1'b1;
        n = 0;
        do
        begin
            @(posedge aclk);
            if (awr === 1'b1)
                awv <= 1'b0;
            if (wrd === 1'b1)
                wv <= 1'b0;
            n = n + 1;
        end
        while (bv !== 1'b1 && n < 60);
        rs = bresp;
        bry <= 1'b0;
        if (bv !== 1'b1)
            fail_count = fail_count + 1;
    end
    endtask

    task rdr(input [7:0] ad);
        integer n;
    begin
        @(posedge aclk);
        ara <= ad;
        arv <= 1'b1;
        rry <= 1'b1;
        n = 0;
        do
        begin
            @(posedge aclk);
            if (arr === 1'b1)
                arv <= 1'b0;
            n = n + 1;
        end
        while (rv !== 1'b1 && n < 60);
        rd = rdat;
        rs = rresp;
        rry <= 1'b0;
        if (rv !== 1'b1)
            fail_count = fail_count + 1;
    end
    endtask

    initial
    begin
        #(50 * 20000);
        fail_count = fail_count + 1;
        tally_and_finish;
    end

    initial
    begin
        acc_m = 8'h00;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (3) @(posedge aclk);
        rdr(`CPUSB_OFF_PSW);
        chk_data(rd, 32'h0000_0000);
        for (i = 0; i < 4; i = i + 1)
        begin
            a = $random(seed);
            x = $random(seed);
            psw_m = {a[7:5], i[1:0], a[2:1], ^acc_m};
            wr(`CPUSB_OFF_PSW, {24'h0, a[7:5], i[1:0], a[2:0]}, 4'hF);
            chk_resp(rs, `CPUSB_RESP_OKAY);
            rdr(`CPUSB_OFF_PSW);
            chk_data(rd, {24'h0, psw_m});
            chk_data({30'h0, bank}, i);
            wr(`CPUSB_OFF_WREG_SEL, {29'h0, a[5:3]}, 4'h1);
            rdr(`CPUSB_OFF_WREG_SEL);
            chk_data(rd, {27'h0, i[1:0], a[5:3]});
            wr(`CPUSB_OFF_WREG_DATA, {24'h0, x[7:0]}, 4'h1);
            wr(`CPUSB_OFF_IRAM_ADDR, {27'h0, i[1:0], a[5:3]}, 4'h1);
            rdr(`CPUSB_OFF_IRAM_ADDR);
            chk_data(rd, {23'h0, 4'h8, i[1:0], a[5:3]});
            rdr(`CPUSB_OFF_IRAM_DATA);
            chk_data(rd, {24'h0, x[7:0]});
            rdr(`CPUSB_OFF_WREG_DATA);
            chk_data(rd, {24'h0, x[7:0]});
            chk_resp(rs, `CPUSB_RESP_OKAY);
        end
        wr(`CPUSB_OFF_IRAM_ADDR, 32'h0000_0020, 4'h1);
        rdr(`CPUSB_OFF_IRAM_ADDR);
        chk_data(rd, 32'h0000_0020);
        for (i = 0; i < 6; i = i + 1)
        begin
            acc_m = $random(seed);
            wr(`CPUSB_OFF_ACC, {24'h0, acc_m}, 4'h1);
            repeat (3) @(posedge aclk);
            chk_data({31'h0, par}, {31'h0, ^acc_m});
            rdr(`CPUSB_OFF_PSW);
            chk_data(rd, {24'h0, psw_m[7:1], ^acc_m});
        end
        for (i = 0; i < 12; i = i + 1)
        begin
            a = $random(seed);
            if (i < 4)
                a = i == 0 ? 8'hD0 : i == 1 ? 8'h80 : i == 2 ? 8'h7F : 8'hF8;
            wr(`CPUSB_OFF_SFR_PROBE, {24'h0, a}, 4'h1);
            rdr(`CPUSB_OFF_SFR_PROBE);
            chk_data(rd, {21'h0, a == 8'hD0, a[7] && a[2:0] == 3'h0,
                          a[7], a});
        end
        for (i = 0; i < 8; i = i + 1)
        begin
            x = $random(seed);
            if (i < 3)
                x = i == 0 ? 16'hF7FF : i == 1 ? XB : 16'hFFFF;
            wr(`CPUSB_OFF_XDATA, {16'h0, x}, 4'h3);
            rdr(`CPUSB_OFF_XDATA);
            chk_data(rd, {15'h0, (x - XB) < 16'h0800, x});
            wr(`CPUSB_OFF_PC, {16'h0, ~x}, 4'h3);
            rdr(`CPUSB_OFF_PC);
            chk_data(rd, {16'h0, ~x});
        end
        wr(8'h28, 32'hFFFF_FFFF, 4'hF);
        chk_resp(rs, `CPUSB_RESP_SLVERR);
        rdr(8'h28);
        chk_resp(rs, `CPUSB_RESP_SLVERR);
        @(posedge aclk);
        pin_n <= 1'b0;
        repeat (24) @(posedge aclk);
        chk_data({28'h0, crst, par, bank}, 32'h0000_0008);
        pin_n <= 1'b1;
        repeat (4) @(posedge aclk);
        rdr(`CPUSB_OFF_STATUS);
        chk_data(rd, 32'h0000_0000);
        rdr(`CPUSB_OFF_PSW);
        chk_data(rd, 32'h0000_0000);
        tally_and_finish;
    end
endmodule // cpu_status_bank_select_reset_test
